// *** rtl/mmsl_link.sv ***
/*
  Monitor-mode serial link command interpreter.
  Assumes a synchronous pin input, a memory port answering reads in the
  same cycle as the strobe, a core that starts when runStart pulses, and
  porPulse held high through the first clock edge after a power-on reset.
*/
// Operation
// - Blank-vector monitor entry survives pin reset
// - Monitor mode selects $FE page vectors
// - NRZ framing, same rate both directions
// - Break is ten low bit periods
// - On break: two high bits, then break
// - High-voltage entry: divide 1024 or 512
// - Normal-voltage entry always divides by 1024
// - Bus rate scales bit rate proportionally
// - Six commands accepted
// - Every received byte is echoed
// - Eleven-bit wait before acting; break cancels
// - Two-bit delay before echo and reply
// - Read data follows final echo
// - Read: opcode, address high, low, data
// - Indexed commands step consecutive addresses
// - Stack read returns SP plus one
// - Eight security bytes, then ready break
`timescale 1ns/1ps
`default_nettype none
module mmsl_link
  import mmsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic porPulse,
  input wire logic blankVector,
  input wire logic testHighVoltage,
  input wire logic dividerSelectPin,
  input wire logic monitorSerialPinIn,
  output logic monitorSerialPinOut,
  output logic monitorSerialPinOe,
  output logic monitorMode,
  output logic [15:0] resetVectorAddr,
  output logic [15:0] swiVectorAddr,
  output logic memRead,
  output logic memWrite,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  input wire logic [15:0] stackPointer,
  output logic runStart
);
  typedef struct packed {
    logic entryDone;
    logic monitor;
    logic sticky;
    logic longDiv;
    mmsl_state_t st;
    logic [3:0] cnt;
    logic [7:0] op;
    logic [15:0] ptr;
    logic [7:0] wdata;
    logic [7:0] rbuf;
    logic [7:0] reply2;
    logic [1:0] replyLeft;
    logic [2:0] step;
    logic [7:0] echoByte;
    logic echoPend;
    logic memRead;
    logic memWrite;
    logic runStart;
    logic txStart;
    logic [1:0] txKind;
    logic [3:0] txBits;
    logic [7:0] txData;
  } mmsl_link_t;
  mmsl_link_t q, d;

  logic rxValid, rxBreak, txBusy;
  logic [7:0] rxData;
  logic [10:0] bitDiv;

  function automatic logic isRead(input logic [7:0] op);
    isRead = (op == OP_READ) || (op == OP_INDEXED_READ_CMD) || (op == OP_SPREAD);
  endfunction

  function automatic logic hasAddr(input logic [7:0] op);
    hasAddr = (op == OP_READ) || (op == OP_WRITE);
  endfunction

  assign bitDiv = q.longDiv ? DIV_LONG : DIV_SHORT;

  mmsl_uart u_uart (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bitDiv(bitDiv),
    .pinIn(monitorSerialPinIn),
    .pinOut(monitorSerialPinOut),
    .pinOe(monitorSerialPinOe),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxBreak(rxBreak),
    .txStart(q.txStart),
    .txKind(q.txKind),
    .txBits(q.txBits),
    .txData(q.txData),
    .txBusy(txBusy)
  );

  // Transmit sequence steps: 0 idle, 1 gap before echo, 2 echo,
  // 3 gap before reply, 4 reply byte, 5 break pending, 6 break gap, 7 break out
  always_comb begin
    d = q;
    d.memRead = 1'b0;
    d.memWrite = 1'b0;
    d.runStart = 1'b0;
    d.txStart = 1'b0;
    // Mode is caught once after reset release, never from the reset itself
    if (!q.entryDone) begin
      d.entryDone = 1'b1;
      if (q.sticky && !porPulse) begin
        // Blank-vector entry outlives a pin reset; only power-on leaves it
        d.monitor = 1'b1;
        d.longDiv = 1'b1;
      end else begin
        d.monitor = blankVector || testHighVoltage;
        d.sticky = blankVector && !testHighVoltage;
        d.longDiv = !testHighVoltage || dividerSelectPin;
      end
    end
    if (q.memRead) d.rbuf = memRdata;

    if (q.entryDone && q.monitor) begin
      if (rxBreak) begin
        // Break abandons any command under way and is answered; the security state is kept
        d.st = (q.st == ST_SECURE) ? ST_SECURE : ST_OPCODE;
        d.step = 3'd5;
        d.echoPend = 1'b0;
        d.replyLeft = 2'd0;
      end else if (rxValid) begin
        d.echoByte = rxData;
        d.echoPend = 1'b1;
        case (q.st)
          ST_SECURE: begin
            // Stay here until the last echo is out, then the ready break follows
            d.echoPend = 1'b1;
            if (q.cnt != 4'hf) d.cnt = q.cnt + 4'h1;
          end
          ST_OPCODE, ST_IDLE: begin
            d.op = rxData;
            if (hasAddr(rxData)) d.st = ST_ADDRH;
            else if (rxData == OP_INDEXED_WRITE_CMD) d.st = ST_DATA;
            else if (rxData == OP_INDEXED_READ_CMD || rxData == OP_SPREAD || rxData == OP_RUN)
              d.st = ST_WAIT;
            else d.st = ST_OPCODE;
          end
          ST_ADDRH: begin
            d.ptr[15:8] = rxData;
            d.st = ST_ADDRL;
          end
          ST_ADDRL: begin
            d.ptr[7:0] = rxData;
            d.st = (q.op == OP_WRITE) ? ST_DATA : ST_WAIT;
          end
          ST_DATA: begin
            d.wdata = rxData;
            d.st = ST_WAIT;
          end
          default: d.st = q.st;
        endcase
      end

      // Transmit sequencer
      if (!txBusy && !q.txStart) begin
        case (q.step)
          3'd0: begin
            if (q.echoPend && !rxBreak) begin
              d.step = 3'd1;
              d.txStart = 1'b1;
              d.txKind = 2'd3;
              d.txBits = ECHO_DELAY_BITS;
            end else if (q.replyLeft != 2'd0) begin
              d.step = 3'd3;
              d.txStart = 1'b1;
              d.txKind = 2'd3;
              d.txBits = ECHO_DELAY_BITS;
            end else if (q.st == ST_SECURE && q.cnt >= SECURITY_BYTES) begin
              d.cnt = 4'h0;
              d.st = ST_IDLE;
              d.step = 3'd6;
            end else if (q.st == ST_WAIT) begin
              // Quiet wait after the final echo; a break here cancels
              d.st = ST_EXEC;
              d.txStart = 1'b1;
              d.txKind = 2'd3;
              d.txBits = CMD_DELAY_BITS;
            end else if (q.st == ST_EXEC && monitorSerialPinIn) begin
              // A low pin here is a break begun inside the wait: hold off until
              // it is recognised and cancels the command
              d.st = ST_REPLY;
              case (q.op)
                OP_READ, OP_INDEXED_READ_CMD: begin
                  d.memRead = 1'b1;
                  d.replyLeft = 2'd1;
                end
                OP_WRITE, OP_INDEXED_WRITE_CMD: d.memWrite = 1'b1;
                OP_SPREAD: d.replyLeft = 2'd2;
                OP_RUN: d.runStart = 1'b1;
                default: d.st = ST_OPCODE;
              endcase
              if (q.op == OP_SPREAD) begin
                {d.rbuf, d.reply2} = stackPointer + 16'h0001;
              end
            end else if (q.st == ST_REPLY) begin
              d.st = ST_OPCODE;
              // Indexed access moves the pointer to the next cell
              if (q.op == OP_INDEXED_READ_CMD || q.op == OP_INDEXED_WRITE_CMD) d.ptr = q.ptr + 16'h0001;
            end
          end
          3'd1: begin
            d.step = 3'd2;
            d.echoPend = 1'b0;
            d.txStart = 1'b1;
            d.txKind = 2'd0;
            d.txBits = FRAME_BITS;
            d.txData = q.echoByte;
          end
          3'd2: d.step = 3'd0;
          3'd3: begin
            // Reply only after the final echo has left
            d.step = 3'd4;
            d.txStart = 1'b1;
            d.txKind = 2'd0;
            d.txBits = FRAME_BITS;
            d.txData = q.rbuf;
            d.rbuf = q.reply2;
            d.replyLeft = q.replyLeft - 2'd1;
          end
          3'd4: d.step = 3'd0;
          3'd5: begin
            d.step = 3'd6;
            d.txStart = 1'b1;
            d.txKind = 2'd2;
            d.txBits = BREAK_GAP_BITS;
          end
          3'd6: begin
            d.step = 3'd7;
            d.txStart = 1'b1;
            d.txKind = 2'd1;
            d.txBits = BREAK_LOW_BITS;
          end
          3'd7: begin
            d.step = 3'd0;
          end
          default: d.step = 3'd0;
        endcase
      end
    end
  end

  // The sticky entry flag has no pin reset on purpose: it must outlive rst_b,
  // and only a power-on entry, or any entry while it is clear, rewrites it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q.entryDone <= 1'b0;
      q.monitor <= 1'b0;
      q.longDiv <= 1'b0;
      q.st <= ST_SECURE;
      q.cnt <= 4'h0;
      q.op <= 8'h00;
      q.ptr <= 16'h0000;
      q.wdata <= 8'h00;
      q.rbuf <= 8'h00;
      q.reply2 <= 8'h00;
      q.replyLeft <= 2'h0;
      q.step <= 3'h0;
      q.echoByte <= 8'h00;
      q.echoPend <= 1'b0;
      q.memRead <= 1'b0;
      q.memWrite <= 1'b0;
      q.runStart <= 1'b0;
      q.txStart <= 1'b0;
      q.txKind <= 2'h0;
      q.txBits <= 4'h0;
      q.txData <= 8'h00;
    end else begin
      q <= d;
    end
  end

  assign monitorMode = q.monitor;
  assign resetVectorAddr = q.monitor ? VEC_RESET_MON : VEC_RESET_USER;
  assign swiVectorAddr = q.monitor ? VEC_SWI_MON : VEC_SWI_USER;
  assign memRead = q.memRead;
  assign memWrite = q.memWrite;
  assign memAddr = q.ptr;
  assign memWdata = q.wdata;
  assign runStart = q.runStart;
endmodule // mmsl_link
`default_nettype wire

// *** rtl/mmsl_pkg.sv ***
/*
  Package for the monitor-mode serial link: command opcodes, vectors,
  bit-period divisors and timing counts.
  Assumes a 50 MHz system clock and a 16-bit memory address space.
*/
package mmsl_pkg;
  localparam int unsigned SYS_CLK_HZ = 50000000;
  // Bit period is the bus clock divided by one of these
  localparam logic [10:0] DIV_LONG = 11'h400;
  localparam logic [10:0] DIV_SHORT = 11'h200;
  // Reference setting: 2.4576 MHz bus with divide 256 gives 9600 bit/s
  localparam int unsigned REF_BUS_HZ = 2457600;
  localparam int unsigned REF_BAUD = 9600;
  // Frame shape
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [3:0] BREAK_LOW_BITS = 4'ha;
  localparam logic [3:0] BREAK_GAP_BITS = 4'h2;
  localparam logic [3:0] ECHO_DELAY_BITS = 4'h2;
  localparam logic [3:0] CMD_DELAY_BITS = 4'hb;
  localparam logic [3:0] SECURITY_BYTES = 4'h8;
  // Command opcodes
  localparam logic [7:0] OP_READ = 8'h4a;
  localparam logic [7:0] OP_WRITE = 8'h49;
  localparam logic [7:0] OP_INDEXED_READ_CMD = 8'h1a;
  localparam logic [7:0] OP_INDEXED_WRITE_CMD = 8'h19;
  localparam logic [7:0] OP_SPREAD = 8'h0c;
  localparam logic [7:0] OP_RUN = 8'h28;
  // Vectors (high byte addresses)
  localparam logic [15:0] VEC_RESET_USER = 16'hfffe;
  localparam logic [15:0] VEC_SWI_USER = 16'hfffc;
  localparam logic [15:0] VEC_RESET_MON = 16'hfefe;
  localparam logic [15:0] VEC_SWI_MON = 16'hfefc;

  typedef enum logic [3:0] {
    ST_SECURE = 4'h0,
    ST_OPCODE = 4'h1,
    ST_ADDRH = 4'h3,
    ST_ADDRL = 4'h2,
    ST_DATA = 4'h6,
    ST_WAIT = 4'h7,
    ST_EXEC = 4'h5,
    ST_REPLY = 4'h4,
    ST_IDLE = 4'hc
  } mmsl_state_t;
endpackage

// *** rtl/mmsl_uart.sv ***
/*
  Bit engine of the monitor link: receives NRZ frames on the wired-OR pin,
  recognises break, and sends bytes, breaks or an idle-high gap.
  Assumes the pin input is synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mmsl_uart
  import mmsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [10:0] bitDiv,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxBreak,
  input wire logic txStart,
  input wire logic [1:0] txKind,
  input wire logic [3:0] txBits,
  input wire logic [7:0] txData,
  output logic txBusy
);
  typedef struct packed {
    logic rxAct;
    logic [10:0] rxCnt;
    logic [3:0] rxBit;
    logic [8:0] rxSh;
    logic rxValid;
    logic rxBreak;
    logic [7:0] rxData;
    logic txAct;
    logic [10:0] txCnt;
    logic [3:0] txBit;
    logic [3:0] txLen;
    logic [1:0] txKind;
    logic [9:0] txSh;
    logic pinOut;
  } mmsl_uart_t;
  mmsl_uart_t q, d;

  // Kinds: 0 byte frame, 1 break, 2 idle high gap, 3 silent delay
  always_comb begin
    d = q;
    d.rxValid = 1'b0;
    d.rxBreak = 1'b0;
    if (!q.rxAct) begin
      // Half duplex only while our own frame or break is on the pin; the quiet delays
      // keep listening so that a break can cancel a command
      if (!pinIn && (!q.txAct || q.txKind[1])) begin
        d.rxAct = 1'b1;
        d.rxCnt = {1'b0, bitDiv[10:1]};
        d.rxBit = 4'h0;
      end
    end else if (q.rxCnt == 11'h000) begin
      d.rxCnt = bitDiv - 11'h001;
      d.rxSh = {pinIn, q.rxSh[8:1]};
      d.rxBit = q.rxBit + 4'h1;
      if (q.rxBit == FRAME_BITS - 4'h1) begin
        d.rxAct = 1'b0;
        // Ten low samples, stop bit included, mark a break
        if (!pinIn && q.rxSh == 9'h000) d.rxBreak = 1'b1;
        else if (pinIn) begin
          d.rxValid = 1'b1;
          d.rxData = q.rxSh[8:1];
        end
      end
    end else begin
      d.rxCnt = q.rxCnt - 11'h001;
    end
    if (!q.txAct) begin
      d.pinOut = 1'b1;
      if (txStart) begin
        d.txAct = 1'b1;
        d.txKind = txKind;
        d.txLen = txBits;
        d.txBit = 4'h0;
        d.txCnt = bitDiv - 11'h001;
        // NRZ frame: start low, data LSB first, stop high
        d.txSh = (txKind == 2'd0) ? {1'b1, txData, 1'b0} : 10'h000;
        d.pinOut = (txKind[1]) ? 1'b1 : d.txSh[0];
      end
    end else if (q.txCnt == 11'h000) begin
      d.txCnt = bitDiv - 11'h001;
      d.txBit = q.txBit + 4'h1;
      d.txSh = {1'b1, q.txSh[9:1]};
      if (q.txBit == q.txLen - 4'h1) begin
        d.txAct = 1'b0;
        d.pinOut = 1'b1;
      end else begin
        d.pinOut = q.txKind[1] ? 1'b1 : d.txSh[0];
      end
    end else begin
      d.txCnt = q.txCnt - 11'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.pinOut <= 1'b1;
      q.txSh <= 10'h3ff;
    end else begin
      q <= d;
    end
  end

  assign rxValid = q.rxValid;
  assign rxBreak = q.rxBreak;
  assign rxData = q.rxData;
  assign txBusy = q.txAct;
  assign pinOut = q.pinOut;
  // Wired-OR pin: drive only lows; the idle-high gap is driven actively
  assign pinOe = q.txAct && (!q.pinOut || q.txKind == 2'd2);
endmodule // mmsl_uart
`default_nettype wire

// *** verif/mmsl_host_model.sv ***
/*
  Host side of the single-wire monitor link: sends frames, receives frames.
  Assumes the bench resolves the wired-OR pin with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module mmsl_host_model (
  input wire logic sys_clk,
  input wire logic pin,
  output var logic hostLow
);
  initial hostLow = 1'b0;
  // Bits go out LSB first, index 0 is the start bit
  task automatic send_frame(input int bitLen, input logic [9:0] bits);
    int i;
    for (i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      #1;
      hostLow = ~bits[i];
      repeat (bitLen - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    #1;
    hostLow = 1'b0;
  endtask
  // Samples mid-bit at the host's own rate, so a rate mismatch garbles data
  task automatic get_frame(input int bitLen, output logic [7:0] d, output logic brk,
                           output int waitCyc);
    int i;
    logic [9:0] f;
    waitCyc = 0;
    while (pin !== 1'b0 && waitCyc < 40000) begin
      @(posedge sys_clk);
      waitCyc++;
    end
    repeat (bitLen / 2) @(posedge sys_clk);
    for (i = 0; i < 10; i++) begin
      f[i] = pin;
      repeat (bitLen) @(posedge sys_clk);
    end
    d = f[8:1];
    brk = (f == 10'h000);
  endtask
endmodule // mmsl_host_model
`default_nettype wire

// *** verif/mmsl_link_monitor.sv ***
/*
  Checker on the ports of the monitor link top.
  Assumes a bind from the bench and the single sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module mmsl_link_monitor
  import mmsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic monitorMode,
  input wire logic [15:0] resetVectorAddr,
  input wire logic [15:0] swiVectorAddr,
  input wire logic monitorSerialPinOut,
  input wire logic monitorSerialPinOe,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic runStart
);
  logic drvLow;
  logic [15:0] lowRun_q;
  assign drvLow = monitorSerialPinOe & ~monitorSerialPinOut;
  // Both divisors are multiples of 512, so any low run must be too
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowRun_q <= 16'h0;
    end else begin
      lowRun_q <= drvLow ? lowRun_q + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence low_end;
    $fell(drvLow);
  endsequence
  sequence strobe_gone(s);
    !s;
  endsequence
  AST_RESET_VECTOR: assert property ($stable(monitorMode) |->
    resetVectorAddr == (monitorMode ? VEC_RESET_MON : VEC_RESET_USER))
    else $error("reset vector does not follow mode");
  AST_SWI_VECTOR: assert property ($stable(monitorMode) |->
    swiVectorAddr == (monitorMode ? VEC_SWI_MON : VEC_SWI_USER))
    else $error("swi vector does not follow mode");
  AST_IDLE_HIGH: assert property (!monitorSerialPinOe |-> monitorSerialPinOut)
    else $error("pin value low while not driven");
  AST_LOW_WHOLE_BITS: assert property (low_end |->
    lowRun_q >= 16'd512 && lowRun_q[8:0] == 9'h0)
    else $error("driven low run is not whole bit periods");
  AST_LOW_MAX_BREAK: assert property (low_end |-> lowRun_q <= 16'd10240)
    else $error("driven low run longer than a break");
  AST_READ_PULSE: assert property (memRead |=> strobe_gone(memRead))
    else $error("memRead longer than one cycle");
  AST_WRITE_PULSE: assert property (memWrite |=> strobe_gone(memWrite))
    else $error("memWrite longer than one cycle");
  AST_RUN_PULSE: assert property (runStart |=> strobe_gone(runStart))
    else $error("runStart longer than one cycle");
  AST_STROBE_EXCL: assert property (!(memRead && memWrite))
    else $error("read and write strobes together");
endmodule // mmsl_link_monitor
`default_nettype wire

// *** verif/mmsl_link_test.sv ***
/*
  Self-checking bench for the monitor link: entry modes, echo, break.
  Assumes the host model partner and a pulled-up wired-OR serial pin.
*/
`timescale 1ns/1ps
`default_nettype none
module mmsl_link_test;
  import mmsl_pkg::*;
  logic sys_clk, rst_b, porPulse, blankVector, testHighVoltage, dividerSelectPin;
  logic pinOut, pinOe, monitorMode, memRead, memWrite, runStart, hostLow;
  logic [15:0] resetVectorAddr, swiVectorAddr, memAddr;
  logic [7:0] memWdata;
  wire logic serialPin;
  int fail_count = 0;
  int n_compared = 0;
  assign serialPin = ~(hostLow | (pinOe & ~pinOut));
  mmsl_link mmsl_link_i (.sys_clk(sys_clk), .rst_b(rst_b), .porPulse(porPulse),
    .blankVector(blankVector), .testHighVoltage(testHighVoltage),
    .dividerSelectPin(dividerSelectPin), .monitorSerialPinIn(serialPin),
    .monitorSerialPinOut(pinOut), .monitorSerialPinOe(pinOe), .monitorMode(monitorMode),
    .resetVectorAddr(resetVectorAddr), .swiVectorAddr(swiVectorAddr), .memRead(memRead),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memRdata(8'h00),
    .stackPointer(16'h0000), .runStart(runStart));
  mmsl_host_model mmsl_host_model_i (.sys_clk(sys_clk), .pin(serialPin), .hostLow(hostLow));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk_bit(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_val(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_win(string what, int lo, int hi, int got);
    n_compared++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // Entry pins are only looked at as reset is released
  // A power-on reset keeps porPulse high past the first edge after release
  task automatic do_reset(logic tv, logic ds, logic bv, logic por);
    @(posedge sys_clk);
    #1;
    rst_b = 1'b0;
    porPulse = por;
    testHighVoltage = tv;
    dividerSelectPin = ds;
    blankVector = bv;
    repeat (20) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    porPulse = 1'b0;
  endtask
  task automatic sc_user_mode;
    do_reset(1'b0, 1'b1, 1'b0, 1'b1);
    chk_bit("monitorMode", 1'b0, monitorMode);
    chk_val("resetVectorAddr", VEC_RESET_USER, resetVectorAddr);
    chk_val("swiVectorAddr", VEC_SWI_USER, swiVectorAddr);
  endtask
  task automatic sc_echo(logic tv, logic ds, logic bv, int bitLen, logic [7:0] d);
    logic [7:0] e;
    logic brk;
    int w;
    do_reset(tv, ds, bv, 1'b1);
    chk_bit("monitorMode", 1'b1, monitorMode);
    chk_val("resetVectorAddr", VEC_RESET_MON, resetVectorAddr);
    chk_val("swiVectorAddr", VEC_SWI_MON, swiVectorAddr);
    mmsl_host_model_i.send_frame(bitLen, {1'b1, d, 1'b0});
    mmsl_host_model_i.get_frame(bitLen, e, brk, w);
    chk_val("echo", {8'h00, d}, {8'h00, e});
    chk_win("echo gap", bitLen, 5 * bitLen / 2, w);
  endtask
  task automatic sc_break(int bitLen);
    logic [7:0] e;
    logic brk;
    int w;
    repeat (bitLen) @(posedge sys_clk);
    #1;
    mmsl_host_model_i.send_frame(bitLen, 10'h000);
    repeat (bitLen) @(posedge sys_clk);
    #1;
    chk_bit("gap drive", 1'b1, pinOe);
    chk_bit("gap level", 1'b1, serialPin);
    mmsl_host_model_i.get_frame(bitLen, e, brk, w);
    chk_bit("break echo", 1'b1, brk);
    chk_win("break gap", bitLen / 4, 7 * bitLen / 4, w);
  endtask
  // Follows a blank-vector entry: a pin reset keeps monitor mode, power-on ends it
  task automatic sc_sticky;
    do_reset(1'b0, 1'b0, 1'b0, 1'b0);
    chk_bit("sticky monitorMode", 1'b1, monitorMode);
    chk_val("sticky resetVectorAddr", VEC_RESET_MON, resetVectorAddr);
    do_reset(1'b0, 1'b0, 1'b0, 1'b1);
    chk_bit("por monitorMode", 1'b0, monitorMode);
    chk_val("por resetVectorAddr", VEC_RESET_USER, resetVectorAddr);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    porPulse = 1'b1;
    blankVector = 1'b0;
    testHighVoltage = 1'b0;
    dividerSelectPin = 1'b0;
    sc_user_mode();
    sc_echo(1'b1, 1'b0, 1'b0, 512, 8'hc5);
    sc_break(512);
    sc_echo(1'b1, 1'b1, 1'b0, 1024, 8'h3a);
    sc_echo(1'b0, 1'b0, 1'b1, 1024, 8'h5c);
    sc_sticky();
    stop_test();
  end
  // Planned traffic needs about 70k cycles; allow 90k
  initial begin
    #1800000;
    fail_count++;
    stop_test();
  end
endmodule // mmsl_link_test
bind mmsl_link mmsl_link_monitor mmsl_link_monitor_i (.sys_clk(sys_clk), .rst_b(rst_b),
  .monitorMode(monitorMode), .resetVectorAddr(resetVectorAddr),
  .swiVectorAddr(swiVectorAddr), .monitorSerialPinOut(monitorSerialPinOut),
  .monitorSerialPinOe(monitorSerialPinOe), .memRead(memRead), .memWrite(memWrite),
  .runStart(runStart));
`default_nettype wire
